/* File: shared/dpa_pkg.sv */
// constants and types shared by the phase accumulator and its modulation memory
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dpa_pkg;
   localparam int unsigned ACC_W      = 48;
   localparam int unsigned DAC_W      = 12;
   localparam int unsigned WADDR_W    = DAC_W + 2;
   localparam int unsigned FRAC_W     = ACC_W - WADDR_W;
   localparam int unsigned MEM_AW     = 14;
   localparam int unsigned MEM_DW     = 16;
   localparam int unsigned CLK_MHZ    = 200;
   localparam int unsigned MIN_LOAD_MBPS  = 10;
   localparam int unsigned MAX_SWEEP_LIST = 4000;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_SEL       = 8'h04;
   localparam logic [7:0] OFS_FIRST_LO  = 8'h08;
   localparam logic [7:0] OFS_FIRST_HI  = 8'h0C;
   localparam logic [7:0] OFS_SECOND_LO = 8'h10;
   localparam logic [7:0] OFS_SECOND_HI = 8'h14;
   localparam logic [7:0] OFS_RECLEN    = 8'h18;
   localparam logic [7:0] OFS_DWELL     = 8'h1C;
   localparam logic [7:0] OFS_MEM_ADDR  = 8'h20;
   localparam logic [7:0] OFS_MEM_DATA  = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   localparam logic [7:0] OFS_PHASE_HI  = 8'h2C;

   // control bit positions
   localparam int unsigned CTRL_GO   = 0;
   localparam int unsigned CTRL_ARB  = 1;
   localparam int unsigned CTRL_TRIG = 2;
   localparam int unsigned CTRL_STOP = 3;

   // reset values
   localparam logic [ACC_W-1:0]   RST_STEP   = 48'h0000_0000_0000;
   localparam logic [WADDR_W-1:0] RST_RECLEN = 14'h0000;
   localparam logic [31:0]        RST_DWELL  = 32'h0000_0000;

   // opcodes in word bits [15:12], argument in [11:0]
   typedef enum logic [3:0] {
      OP_HALT  = 4'b0000,
      OP_LOAD  = 4'b0001,
      OP_SWAP  = 4'b0010,
      OP_PULSE = 4'b0011,
      OP_WAIT  = 4'b0100,
      OP_JUMP  = 4'b0101,
      OP_SWEEP = 4'b0110,
      OP_TRIG  = 4'b0111
   } dpa_op_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_EXEC  = 3'b010,
      S_ARGF  = 3'b011,
      S_ARG   = 3'b100,
      S_DWELL = 3'b101,
      S_PULSE = 3'b110,
      S_WAIT  = 3'b111
   } dpa_state_t;
endpackage

/* File: shared/dpa_mem_if.sv */
// carrier between the accumulator top and its modulation memory
`timescale 1ns/100ps
interface dpa_mem_if;
   logic                       wr_en;
   logic [dpa_pkg::MEM_AW-1:0] wr_addr;
   logic [dpa_pkg::MEM_DW-1:0] wr_data;
   logic [dpa_pkg::MEM_AW-1:0] rd_addr;
   logic [dpa_pkg::MEM_DW-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: rtl/dpa_mod_ram.sv */
// modulation memory: one write port, one registered read port
`timescale 1ns/100ps
module dpa_mod_ram
(
   input  wire logic i_clk,
   dpa_mem_if.mem    mem
);
   logic [dpa_pkg::MEM_DW-1:0] store [0:(1<<dpa_pkg::MEM_AW)-1];
   logic [dpa_pkg::MEM_DW-1:0] rd_data_reg;

   always_ff @(posedge i_clk)
   begin
      if (mem.wr_en)
      begin
         store[mem.wr_addr] <= mem.wr_data;
      end
      rd_data_reg <= store[mem.rd_addr];
   end

   assign mem.rd_data = rd_data_reg;
endmodule

/* File: rtl/dpa_top.sv */
// phase accumulator with two step registers, modulation processor and AHB-Lite registers
`timescale 1ns/100ps
module dpa_top
(
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_hsel,
   input  wire logic [31:0]                  i_haddr,
   input  wire logic [1:0]                   i_htrans,
   input  wire logic                         i_hwrite,
   input  wire logic [2:0]                   i_hsize,
   input  wire logic [31:0]                  i_hwdata,
   input  wire logic                         i_hready,
   output logic                              o_hreadyout,
   output logic                              o_hresp,
   output logic [31:0]                       o_hrdata,
   input  wire logic                         i_trig,
   output logic [dpa_pkg::WADDR_W-1:0]       o_wave_addr,
   output logic                              o_wave_valid,
   input  wire logic                         i_wave_ready
);
   localparam int unsigned AW = dpa_pkg::ACC_W;
   localparam int unsigned WW = dpa_pkg::WADDR_W;
   localparam int unsigned FW = dpa_pkg::FRAC_W;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // host writes a 48-bit step as a low word and a 16-bit high word
   function automatic logic [AW-1:0] wr_step(input logic [AW-1:0] old, input logic [31:0] d, input logic hi);
      logic [AW-1:0] r;
      r = old;
      if (hi)
      begin
         r[47:32] = d[15:0];
      end
      else
      begin
         r[31:0] = d;
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   dpa_mem_if mem_bus ();

   logic                          bus_wr_reg;
   logic                          bus_rd_pend;
   logic [7:0]                    bus_addr_reg;
   logic [31:0]                   hrdata_reg;
   logic                          addr_ok;
   logic                          host_wr;
   logic [AW-1:0]                 first_reg;
   logic [AW-1:0]                 second_reg;
   logic                          sel_reg;
   logic                          pulse_reg;
   logic                          eff_sel;
   logic                          arb_reg;
   logic                          playing_reg;
   logic [WW-1:0]                 reclen_reg;
   logic [31:0]                   dwell_reg;
   logic [dpa_pkg::MEM_AW-1:0]    maddr_reg;
   logic                          go_pulse;
   logic                          stop_pulse;
   logic                          soft_trig;
   logic                          trig_s1_reg;
   logic                          trig_s2_reg;
   logic                          trig_s3_reg;
   logic                          pin_trig;
   logic                          op_trig;
   logic [AW-1:0]                 phase_reg;
   logic [AW-1:0]                 step_use;
   logic [AW-1:0]                 sum;
   logic [AW-1:0]                 phase_next;
   logic                          acc_run;
   logic                          adv;
   dpa_pkg::dpa_state_t           state_reg;
   logic [dpa_pkg::MEM_AW-1:0]    pc_reg;
   logic [AW-1:0]                 stage_reg;
   logic [1:0]                    word_reg;
   logic                          sweep_reg;
   logic [11:0]                   cnt_reg;
   logic [31:0]                   timer_reg;
   logic                          proc_ld;
   logic                          proc_swap;
   logic [3:0]                    op;
   logic [11:0]                   arg;
   logic [WW-1:0]                 buf0_reg;
   logic [WW-1:0]                 buf1_reg;
   logic [1:0]                    fill_reg;
   logic                          buf_in_ready;
   logic                          buf_pop;

   dpa_mod_ram u_ram
   (
      .i_clk (i_clk),
      .mem   (mem_bus.mem)
   );

   // ------------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ------------------------------------------------------------------
   assign addr_ok     = i_hsel && i_htrans[1] && i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_hrdata    = hrdata_reg;
   assign host_wr     = bus_wr_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         bus_wr_reg   <= 1'b0;
         bus_rd_pend  <= 1'b0;
         bus_addr_reg <= 8'h00;
      end
      else
      begin
         bus_wr_reg  <= addr_ok && i_hwrite;
         bus_rd_pend <= addr_ok && !i_hwrite;
         if (addr_ok)
         begin
            bus_addr_reg <= {i_haddr[7:2], 2'b00};
         end
      end
   end

   // read data sampled in the address phase, presented in the data phase
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         hrdata_reg <= 32'h0000_0000;
      end
      else if (addr_ok && !i_hwrite)
      begin
         case ({i_haddr[7:2], 2'b00})
            dpa_pkg::OFS_CTRL:      hrdata_reg <= {30'h0000_0000, arb_reg, 1'b0};
            dpa_pkg::OFS_SEL:       hrdata_reg <= {31'h0000_0000, sel_reg};
            dpa_pkg::OFS_FIRST_LO:  hrdata_reg <= first_reg[31:0];
            dpa_pkg::OFS_FIRST_HI:  hrdata_reg <= {16'h0000, first_reg[47:32]};
            dpa_pkg::OFS_SECOND_LO: hrdata_reg <= second_reg[31:0];
            dpa_pkg::OFS_SECOND_HI: hrdata_reg <= {16'h0000, second_reg[47:32]};
            dpa_pkg::OFS_RECLEN:    hrdata_reg <= {18'h0_0000, reclen_reg};
            dpa_pkg::OFS_DWELL:     hrdata_reg <= dwell_reg;
            dpa_pkg::OFS_MEM_ADDR:  hrdata_reg <= {18'h0_0000, maddr_reg};
            dpa_pkg::OFS_STATUS:    hrdata_reg <= {2'b00, phase_reg[AW-1 -: WW], 13'h0000,
                                                   playing_reg, eff_sel, state_reg != dpa_pkg::S_IDLE};
            dpa_pkg::OFS_PHASE_HI:  hrdata_reg <= phase_reg[47:16];
            default:                hrdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // host-side control registers
   // ------------------------------------------------------------------
   assign go_pulse   = host_wr && bus_addr_reg == dpa_pkg::OFS_CTRL && i_hwdata[dpa_pkg::CTRL_GO];
   assign stop_pulse = host_wr && bus_addr_reg == dpa_pkg::OFS_CTRL && i_hwdata[dpa_pkg::CTRL_STOP];
   assign soft_trig  = host_wr && bus_addr_reg == dpa_pkg::OFS_CTRL && i_hwdata[dpa_pkg::CTRL_TRIG];

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         arb_reg    <= 1'b0;
         reclen_reg <= dpa_pkg::RST_RECLEN;
         dwell_reg  <= dpa_pkg::RST_DWELL;
      end
      else if (host_wr)
      begin
         case (bus_addr_reg)
            dpa_pkg::OFS_CTRL:   arb_reg    <= i_hwdata[dpa_pkg::CTRL_ARB];
            dpa_pkg::OFS_RECLEN: reclen_reg <= i_hwdata[WW-1:0];
            dpa_pkg::OFS_DWELL:  dwell_reg  <= i_hwdata;
            default:             arb_reg    <= arb_reg;
         endcase
      end
   end

   // host fills the modulation memory through an auto-incrementing pointer
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         maddr_reg <= '0;
      end
      else if (host_wr && bus_addr_reg == dpa_pkg::OFS_MEM_ADDR)
      begin
         maddr_reg <= i_hwdata[dpa_pkg::MEM_AW-1:0];
      end
      else if (host_wr && bus_addr_reg == dpa_pkg::OFS_MEM_DATA)
      begin
         maddr_reg <= maddr_reg + 1'b1;
      end
   end

   assign mem_bus.wr_en   = host_wr && bus_addr_reg == dpa_pkg::OFS_MEM_DATA;
   assign mem_bus.wr_addr = maddr_reg;
   assign mem_bus.wr_data = i_hwdata[dpa_pkg::MEM_DW-1:0];
   assign mem_bus.rd_addr = pc_reg;

   // ------------------------------------------------------------------
   // step registers and selector
   // ------------------------------------------------------------------
   // a processor load always wins over a host write in the same cycle
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         first_reg  <= dpa_pkg::RST_STEP;
         second_reg <= dpa_pkg::RST_STEP;
      end
      else if (proc_ld)
      begin
         if (sel_reg)
         begin
            first_reg <= {mem_bus.rd_data, stage_reg[31:0]};
         end
         else
         begin
            second_reg <= {mem_bus.rd_data, stage_reg[31:0]};
         end
      end
      else if (host_wr)
      begin
         case (bus_addr_reg)
            dpa_pkg::OFS_FIRST_LO:  first_reg  <= wr_step(first_reg, i_hwdata, 1'b0);
            dpa_pkg::OFS_FIRST_HI:  first_reg  <= wr_step(first_reg, i_hwdata, 1'b1);
            dpa_pkg::OFS_SECOND_LO: second_reg <= wr_step(second_reg, i_hwdata, 1'b0);
            dpa_pkg::OFS_SECOND_HI: second_reg <= wr_step(second_reg, i_hwdata, 1'b1);
            default:                first_reg  <= first_reg;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         sel_reg <= 1'b0;
      end
      else if (proc_swap)
      begin
         sel_reg <= ~sel_reg;
      end
      else if (host_wr && bus_addr_reg == dpa_pkg::OFS_SEL)
      begin
         sel_reg <= i_hwdata[0];
      end
   end

   // the pulse holds until one step has actually been taken
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pulse_reg <= 1'b0;
      end
      else if (state_reg == dpa_pkg::S_EXEC && op == dpa_pkg::OP_PULSE)
      begin
         pulse_reg <= 1'b1;
      end
      else if (adv)
      begin
         pulse_reg <= 1'b0;
      end
   end

   assign eff_sel  = sel_reg ^ pulse_reg;
   assign step_use = eff_sel ? second_reg : first_reg;

   // ------------------------------------------------------------------
   // trigger: pin synchronised, then edge detected
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
      end
      else
      begin
         trig_s1_reg <= i_trig;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
      end
   end

   assign pin_trig = trig_s2_reg && !trig_s3_reg;
   assign op_trig  = state_reg == dpa_pkg::S_EXEC && op == dpa_pkg::OP_TRIG;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         playing_reg <= 1'b0;
      end
      else if (!arb_reg)
      begin
         playing_reg <= 1'b0;
      end
      else if (pin_trig || soft_trig || op_trig)
      begin
         playing_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // accumulator: one 48-bit add per clock when running (not arbitrary-idle) and the buffer accepts
   // ------------------------------------------------------------------
   // stalling on a full buffer keeps every sample but slows the output
   assign acc_run = !arb_reg || playing_reg;
   assign adv     = acc_run && buf_in_ready;
   assign sum     = phase_reg + step_use;

   always_comb
   begin
      phase_next = sum;
      if (arb_reg && reclen_reg != '0 && sum[AW-1 -: WW] >= reclen_reg)
      begin
         phase_next = sum - {reclen_reg, {FW{1'b0}}};
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         phase_reg <= '0;
      end
      else if (arb_reg && !playing_reg)
      begin
         phase_reg <= '0;
      end
      else if (adv)
      begin
         phase_reg <= phase_next;
      end
   end

   // ------------------------------------------------------------------
   // two-entry output buffer toward the waveform memory
   // ------------------------------------------------------------------
   assign buf_in_ready = fill_reg != 2'd2;
   assign buf_pop      = fill_reg != 2'd0 && i_wave_ready;
   assign o_wave_valid = fill_reg != 2'd0;
   assign o_wave_addr  = buf0_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         fill_reg <= 2'd0;
         buf0_reg <= '0;
         buf1_reg <= '0;
      end
      else
      begin
         case ({adv, buf_pop})
            2'b10:
            begin
               fill_reg <= fill_reg + 2'd1;
               if (fill_reg == 2'd0)
               begin
                  buf0_reg <= phase_reg[AW-1 -: WW];
               end
               else
               begin
                  buf1_reg <= phase_reg[AW-1 -: WW];
               end
            end
            2'b01:
            begin
               fill_reg <= fill_reg - 2'd1;
               buf0_reg <= buf1_reg;
            end
            2'b11:
            begin
               if (fill_reg == 2'd1)
               begin
                  buf0_reg <= phase_reg[AW-1 -: WW];
               end
               else
               begin
                  buf0_reg <= buf1_reg;
                  buf1_reg <= phase_reg[AW-1 -: WW];
               end
            end
            default:
            begin
               fill_reg <= fill_reg;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // modulation processor
   // ------------------------------------------------------------------
   // one 16-bit word every two clocks, far above the sustained load rate
   assign op        = mem_bus.rd_data[15:12];
   assign arg       = mem_bus.rd_data[11:0];
   assign proc_ld   = state_reg == dpa_pkg::S_ARG && word_reg == 2'd2;
   assign proc_swap = (proc_ld && sweep_reg) || (state_reg == dpa_pkg::S_EXEC && op == dpa_pkg::OP_SWAP);

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_reg <= dpa_pkg::S_IDLE;
         pc_reg    <= '0;
         stage_reg <= '0;
         word_reg  <= 2'd0;
         sweep_reg <= 1'b0;
         cnt_reg   <= 12'h000;
         timer_reg <= 32'h0000_0000;
      end
      else if (stop_pulse)
      begin
         state_reg <= dpa_pkg::S_IDLE;
      end
      else if (go_pulse)
      begin
         pc_reg    <= '0;
         state_reg <= dpa_pkg::S_FETCH;
      end
      else
      begin
         case (state_reg)
            dpa_pkg::S_IDLE:  state_reg <= dpa_pkg::S_IDLE;
            dpa_pkg::S_FETCH: state_reg <= dpa_pkg::S_EXEC;
            dpa_pkg::S_EXEC:
            begin
               pc_reg    <= pc_reg + 1'b1;
               word_reg  <= 2'd0;
               state_reg <= dpa_pkg::S_FETCH;
               case (op)
                  dpa_pkg::OP_HALT:  state_reg <= dpa_pkg::S_IDLE;
                  dpa_pkg::OP_LOAD:
                  begin
                     sweep_reg <= 1'b0;
                     state_reg <= dpa_pkg::S_ARGF;
                  end
                  dpa_pkg::OP_SWEEP:
                  begin
                     sweep_reg <= 1'b1;
                     cnt_reg   <= arg;
                     if (arg != 12'h000)
                     begin
                        state_reg <= dpa_pkg::S_ARGF;
                     end
                  end
                  dpa_pkg::OP_PULSE: state_reg <= dpa_pkg::S_PULSE;
                  dpa_pkg::OP_WAIT:
                  begin
                     timer_reg <= {20'h0_0000, arg};
                     state_reg <= dpa_pkg::S_WAIT;
                  end
                  dpa_pkg::OP_JUMP:  pc_reg <= {2'b00, arg};
                  default:           state_reg <= dpa_pkg::S_FETCH;
               endcase
            end
            dpa_pkg::S_ARGF:  state_reg <= dpa_pkg::S_ARG;
            dpa_pkg::S_ARG:
            begin
               stage_reg[word_reg*16 +: 16] <= mem_bus.rd_data;
               pc_reg    <= pc_reg + 1'b1;
               word_reg  <= word_reg + 2'd1;
               state_reg <= dpa_pkg::S_ARGF;
               if (word_reg == 2'd2)
               begin
                  word_reg  <= 2'd0;
                  timer_reg <= dwell_reg;
                  state_reg <= sweep_reg ? dpa_pkg::S_DWELL : dpa_pkg::S_FETCH;
               end
            end
            dpa_pkg::S_DWELL:
            begin
               timer_reg <= timer_reg - 32'h0000_0001;
               if (timer_reg == 32'h0000_0000)
               begin
                  cnt_reg   <= cnt_reg - 12'h001;
                  state_reg <= cnt_reg == 12'h001 ? dpa_pkg::S_FETCH : dpa_pkg::S_ARGF;
               end
            end
            dpa_pkg::S_PULSE:
            begin
               if (!pulse_reg)
               begin
                  state_reg <= dpa_pkg::S_FETCH;
               end
            end
            dpa_pkg::S_WAIT:
            begin
               timer_reg <= timer_reg - 32'h0000_0001;
               if (timer_reg == 32'h0000_0000)
               begin
                  state_reg <= dpa_pkg::S_FETCH;
               end
            end
            default:          state_reg <= dpa_pkg::S_IDLE;
         endcase
      end
   end
endmodule

/* File: sim/dpa_wave_sink.sv */
// waveform memory side of the address stream, accepting with random stalls
`timescale 1ns/100ps
module dpa_wave_sink
(
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   output logic      o_ready
);
   int seed = 32'h4304;
   // frequent stalls: the stream must hold, not drop, addresses
   always @(posedge i_clk or posedge i_sys_rst)
      if (i_sys_rst)
         o_ready <= 1'b0;
      else
         o_ready <= ($random(seed) & 3) != 0;
endmodule

/* File: sim/dpa_top_asserts.sv */
// port checker for the phase accumulator top
`timescale 1ns/100ps
module dpa_top_asserts
(
   input wire logic                   i_clk,
   input wire logic                   i_sys_rst,
   input wire logic                   i_hsel,
   input wire logic [1:0]             i_htrans,
   input wire logic                   i_hready,
   input wire logic                   o_hreadyout,
   input wire logic                   o_hresp,
   input wire logic [31:0]            o_hrdata,
   input wire logic [dpa_pkg::WADDR_W-1:0] o_wave_addr,
   input wire logic                   o_wave_valid,
   input wire logic                   i_wave_ready
);
   default clocking dck @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   bus_ready_a: assert property (o_hreadyout) else $error("bus stalled");
   bus_okay_a: assert property (!o_hresp) else $error("bus error response");
   wave_start_a: assert property ($fell(i_sys_rst) |-> ##[1:3] o_wave_valid)
      else $error("no address after reset");
   wave_zero_a: assert property ($fell(i_sys_rst) |-> (o_wave_addr == '0) [*3])
      else $error("address not zero after reset");
   stall_valid_a: assert property (o_wave_valid && !i_wave_ready |=> o_wave_valid)
      else $error("address lost in stall");
   stall_addr_a: assert property (o_wave_valid && !i_wave_ready |=> $stable(o_wave_addr))
      else $error("address moved in stall");
   valid_drop_a: assert property ($fell(o_wave_valid) |-> $past(i_wave_ready))
      else $error("valid fell without pop");
   addr_move_a: assert property ($changed(o_wave_addr) |-> !$past(o_wave_valid) || $past(i_wave_ready))
      else $error("address changed without pop");
   rdata_hold_a: assert property (!$past(i_hsel && i_htrans[1] && i_hready) |-> $stable(o_hrdata))
      else $error("read data changed without access");
endmodule
bind dpa_top dpa_top_asserts i_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
   .i_htrans(i_htrans), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_hrdata(o_hrdata), .o_wave_addr(o_wave_addr), .o_wave_valid(o_wave_valid), .i_wave_ready(i_wave_ready));

/* File: sim/testbench.sv */
// self-checking bench: register bus driver, stream monitor and random-stall sink
`timescale 1ns/100ps
module testbench;
   logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_due = 1'b0, have = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, e;
   logic [31:0] q[$];
   logic [15:0] prog [6];
   logic [13:0] last, inc = 14'h0, nxt;
   logic [14:0] len = 15'h4000;
   logic [2:0]  r;
   wire         hready, hresp, wvalid, wready;
   wire  [31:0] hrdata;
   wire  [13:0] waddr;
   int bad_count = 0, check_count = 0, cyc = 0, skip = 1000, seed = 32'h4304;
   always #2.5 clk = ~clk;
   dpa_top i_dpa_top (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hresp(hresp), .o_hrdata(hrdata), .i_trig(1'b0), .o_wave_addr(waddr), .o_wave_valid(wvalid),
      .i_wave_ready(wready));
   dpa_wave_sink i_dpa_wave_sink (.i_clk(clk), .i_sys_rst(rst), .o_ready(wready));
   task check(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (x !== g)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rd_due <= !w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd_due <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      q.push_back(x);
      bus(1'b0, a, 32'h0);
   endtask
   task run(input logic [13:0] s);
      inc <= s;
      skip <= 4;
      repeat (30) @(posedge clk);
   endtask
   // once skip has run down to zero, each accepted address must lie one step past the previous one, stalls or not
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         bad_count++;
         test_done;
      end
      if (rd_due)
      begin
         e = q.pop_front();
         check("read data", e, hrdata);
      end
      if (wvalid === 1'b1 && wready === 1'b1)
      begin
         if (skip == 0 && have)
            check("wave step", {17'h0, ({1'b0, last} + inc) % len}, {18'h0, waddr});
         else if (skip > 0)
            skip--;
         last = waddr;
         have = 1'b1;
      end
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(dpa_pkg::OFS_STATUS, 32'h0);
      rd(8'h30, 32'h0);
      bus(1'b1, dpa_pkg::OFS_FIRST_HI, 32'h4);
      run(14'h1);
      r = $random(seed);
      nxt = 14'(r) + 14'h1;
      bus(1'b1, dpa_pkg::OFS_SECOND_HI, {16'h0, nxt, 2'h0});
      repeat (20) @(posedge clk);
      skip <= 1000;
      bus(1'b1, dpa_pkg::OFS_SEL, 32'h1);
      run(nxt);
      r = $random(seed);
      nxt = 14'(r) + 14'h2;
      prog = '{16'h1000, 16'h0, 16'h0, {nxt, 2'h0}, 16'h2000, 16'h0};
      skip <= 1000;
      bus(1'b1, dpa_pkg::OFS_MEM_ADDR, 32'h0);
      for (int i = 0; i < 6; i++)
         bus(1'b1, dpa_pkg::OFS_MEM_DATA, {16'h0, prog[i]});
      bus(1'b1, dpa_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      run(nxt);
      rd(dpa_pkg::OFS_SEL, 32'h0);
      // arbitrary mode: held at zero until triggered, then wraps at the record length
      bus(1'b1, dpa_pkg::OFS_RECLEN, 32'h15);
      skip <= 1000;
      bus(1'b1, dpa_pkg::OFS_CTRL, 32'h2);
      repeat (4) @(posedge clk);
      rd(dpa_pkg::OFS_STATUS, 32'h0);
      len <= 15'h15;
      bus(1'b1, dpa_pkg::OFS_CTRL, 32'h6);
      run(nxt);
      test_done;
   end
endmodule
